// ==== alarm_pkg.sv ====
// shared constants, register map and types for the alarm latch block
package alarm_pkg;
  localparam int NUM_LOOPS    = 3;
  localparam int NUM_MODS     = 6;
  localparam int NUM_USER     = 8;
  // alarm index map: loops 0..5, process_variable 6..7, analogue 8..9,
  // module low 10..15, module high 16..21, user 22..29
  localparam int IDX_LOOP     = 0;
  localparam int IDX_PV       = 6;
  localparam int IDX_AN       = 8;
  localparam int IDX_MLO      = 10;
  localparam int IDX_MHI      = 16;
  localparam int IDX_USER     = 22;
  localparam int NUM_ALARMS   = 30;
  localparam int MOD_UNFITTED = 1;          // position 2, zero-based index 1
  // group acknowledge bit positions
  localparam int GRP_PV       = 3;
  localparam int GRP_AN       = 4;
  localparam int GRP_MOD      = 5;
  localparam int NUM_GROUPS   = 11;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_COND     = 8'h04;
  localparam logic [7:0] ADDR_LATCH_EN = 8'h08;
  localparam logic [7:0] ADDR_MANUAL   = 8'h0C;
  localparam logic [7:0] ADDR_EVENT    = 8'h10;
  localparam logic [7:0] ADDR_RELAY_EN = 8'h14;
  localparam logic [7:0] ADDR_ACK_GRP  = 8'h18;
  localparam logic [7:0] ADDR_ACK_USER = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ST   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADDR_MSG      = 8'h28;
  localparam logic [7:0] ADDR_SUMMARY  = 8'h2C;
  localparam logic [31:0] ACK_ALL_BIT  = 32'h8000_0000;
  localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
  // beacon flash half period in cycles
  localparam int FLASH_HALF_CYCLES = 50_000_000;
  localparam int NUM_IRQ      = 2;        // bit0 new alarm, bit1 alarm cleared

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [NUM_ALARMS-1:0] latch_en;
    logic [NUM_ALARMS-1:0] manual;
    logic [NUM_ALARMS-1:0] event_only;
  } alarm_cfg_t;
endpackage

// ==== alarm_cell.sv ====
// one latching alarm: condition tracking, acknowledge memory, new-alarm pulse
`timescale 1ns/10ps
`default_nettype none
module alarm_cell
  import alarm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic cond,
  input  wire logic latch_en,
  input  wire logic manual,
  input  wire logic ack,
  output logic      active,
  output logic      unacked,
  output logic      new_pulse
);
  logic active_reg;
  logic ack_seen_reg;
  logic unacked_reg;
  logic cond_d_reg;
  logic active_next;
  logic ack_seen_next;
  logic unacked_next;
  wire  rise = cond & ~cond_d_reg;
  // ack is remembered only in automatic mode while the condition stands
  wire  ack_keep = ack & (~manual | ~cond);

  always_comb begin
    active_next   = active_reg;
    ack_seen_next = ack_seen_reg;
    if (!latch_en) begin
      active_next   = cond;
      ack_seen_next = 1'b0;
    end else if (cond) begin
      active_next = 1'b1;
      if (rise)
        ack_seen_next = 1'b0;
      if (ack_keep)
        ack_seen_next = 1'b1;
    end else if (active_reg && (ack || ack_seen_reg)) begin
      active_next   = 1'b0;
      ack_seen_next = 1'b0;
    end
    unacked_next = unacked_reg;
    if (!active_next && !cond)
      unacked_next = 1'b0;
    else if (ack)
      unacked_next = 1'b0;
    if (rise)
      unacked_next = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
      unacked_reg  <= 1'b0;
      cond_d_reg   <= 1'b0;
    end else begin
      active_reg   <= active_next;
      ack_seen_reg <= ack_seen_next;
      unacked_reg  <= unacked_next;
      cond_d_reg   <= cond;
    end
  end

  assign active    = active_reg;
  assign unacked   = unacked_reg;
  assign new_pulse = rise;
endmodule
`default_nettype wire

// ==== alarm_latch_top.sv ====
// alarm latching, grouping, acknowledge, beacon and relay control with apb access
// How it works
// - latched alarm stays on until acknowledged
// - acknowledge from buttons, digital input, comms
// - auto reset: early acknowledge is remembered
// - manual reset: acknowledge only after clearing
// - three loops, two alarms, group acknowledge
// - pv and analogue low/high with group ack
// - modules 1,3-6 only; position 2 reads zero
// - eight user alarms as status vector
// - each user alarm acknowledged individually
// - new alarm flashes beacon, requests message
// - assigned relay energised while alarm active
// - events update status, no beacon, no message
// - after ack beacon steady; new alarm reflashes
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module alarm_latch_top
  import alarm_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NUM_ALARMS-1:0] alarm_cond,
  input  wire logic                  button_ack_pin,
  input  wire logic                  digital_ack_pin,
  input  wire logic                  global_ack_pin,
  output logic                       beacon_on,
  output logic                       message_request,
  output logic      [4:0]            message_source,
  output logic      [NUM_ALARMS-1:0] relay_out,
  output logic      [2*NUM_LOOPS-1:0] loop_alarm_status_pair,
  output logic      [1:0]            process_variable_status,
  output logic      [1:0]            analogue_status,
  output logic      [NUM_MODS-1:0]   module_low_status_vector,
  output logic      [NUM_MODS-1:0]   module_high_status_vector,
  output logic      [NUM_USER-1:0]   user_status_vector,
  output logic                       irq
);
  apb_req_t req;
  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  logic [NUM_ALARMS-1:0] cond_s1_reg;
  logic [NUM_ALARMS-1:0] cond_s2_reg;
  logic [2:0]            pin_s1_reg;
  logic [2:0]            pin_s2_reg;
  logic [2:0]            pin_d_reg;
  alarm_cfg_t            cfg_reg;
  logic [NUM_ALARMS-1:0] relay_en_reg;
  logic [NUM_IRQ-1:0]    irq_st_reg;
  logic [NUM_IRQ-1:0]    irq_mask_reg;
  logic [4:0]            msg_src_reg;
  logic                  msg_req_reg;
  logic                  beacon_reg;
  logic [31:0]           prdata_reg;
  logic [31:0]           flash_cnt_reg;
  logic                  flash_ph_reg;

  logic [NUM_ALARMS-1:0] active;
  logic [NUM_ALARMS-1:0] unacked;
  logic [NUM_ALARMS-1:0] new_pulse;
  logic [NUM_ALARMS-1:0] ack_vec;
  logic [NUM_ALARMS-1:0] fitted;

  // apb decode
  wire wr_en   = req.psel & req.penable & req.pwrite;
  wire rd_en   = req.psel & req.penable & ~req.pwrite;
  wire hit_st  = req.paddr == ADDR_STATUS;
  wire hit_cd  = req.paddr == ADDR_COND;
  wire hit_le  = req.paddr == ADDR_LATCH_EN;
  wire hit_mn  = req.paddr == ADDR_MANUAL;
  wire hit_ev  = req.paddr == ADDR_EVENT;
  wire hit_re  = req.paddr == ADDR_RELAY_EN;
  wire hit_ag  = req.paddr == ADDR_ACK_GRP;
  wire hit_au  = req.paddr == ADDR_ACK_USER;
  wire hit_is  = req.paddr == ADDR_IRQ_ST;
  wire hit_im  = req.paddr == ADDR_IRQ_MASK;
  wire hit_ms  = req.paddr == ADDR_MSG;
  wire hit_sm  = req.paddr == ADDR_SUMMARY;
  wire mapped  = hit_st | hit_cd | hit_le | hit_mn | hit_ev | hit_re | hit_ag | hit_au
               | hit_is | hit_im | hit_ms | hit_sm;
  assign pready  = 1'b1;
  assign pslverr = req.psel & req.penable & ~mapped;

  // acknowledge sources: comms write pulse, pin rising edges
  wire button_ack = pin_s2_reg[0] & ~pin_d_reg[0];
  wire dig_ack    = pin_s2_reg[1] & ~pin_d_reg[1];
  wire pin_global = pin_s2_reg[2] & ~pin_d_reg[2];
  wire comm_grp   = wr_en & hit_ag;
  wire comm_user  = wr_en & hit_au;
  wire ack_all    = button_ack | dig_ack | pin_global
                  | (comm_grp & |(req.pwdata & ACK_ALL_BIT));
  wire [NUM_GROUPS-1:0] grp_ack =
      ({NUM_GROUPS{comm_grp}} & req.pwdata[NUM_GROUPS-1:0]) | {NUM_GROUPS{ack_all}};
  wire [NUM_USER-1:0] user_ack =
      ({NUM_USER{comm_user}} & req.pwdata[NUM_USER-1:0]) | {NUM_USER{ack_all}};

  // per-alarm acknowledge and fitted map
  genvar g;
  generate
    for (g = 0; g < NUM_ALARMS; g++) begin : g_alm
      if (g < IDX_PV) begin : g_loop
        assign ack_vec[g] = grp_ack[g/2];
        assign fitted[g]  = 1'b1;
      end else if (g < IDX_AN) begin : g_pv
        assign ack_vec[g] = grp_ack[GRP_PV];
        assign fitted[g]  = 1'b1;
      end else if (g < IDX_MLO) begin : g_an
        assign ack_vec[g] = grp_ack[GRP_AN];
        assign fitted[g]  = 1'b1;
      end else if (g < IDX_USER) begin : g_mod
        // low and high of a module share one group bit
        assign ack_vec[g] = grp_ack[GRP_MOD + ((g - IDX_MLO) % NUM_MODS)];
        assign fitted[g]  = ((g - IDX_MLO) % NUM_MODS) != MOD_UNFITTED;
      end else begin : g_usr
        assign ack_vec[g] = user_ack[g - IDX_USER];
        assign fitted[g]  = 1'b1;
      end
      alarm_cell u_cell (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .cond      (cond_s2_reg[g] & fitted[g]),
        .latch_en  (cfg_reg.latch_en[g]),
        .manual    (cfg_reg.manual[g]),
        .ack       (ack_vec[g]),
        .active    (active[g]),
        .unacked   (unacked[g]),
        .new_pulse (new_pulse[g])
      );
    end
  endgenerate

  // status views
  assign loop_alarm_status_pair    = active[IDX_PV-1:IDX_LOOP];
  assign process_variable_status   = active[IDX_AN-1:IDX_PV];
  assign analogue_status           = active[IDX_MLO-1:IDX_AN];
  assign module_low_status_vector  = active[IDX_MHI-1:IDX_MLO] & fitted[IDX_MHI-1:IDX_MLO];
  assign module_high_status_vector = active[IDX_USER-1:IDX_MHI] & fitted[IDX_USER-1:IDX_MHI];
  assign user_status_vector        = active[NUM_ALARMS-1:IDX_USER];

  // beacon and message, events excluded
  wire [NUM_ALARMS-1:0] vis      = ~cfg_reg.event_only;
  wire [NUM_ALARMS-1:0] new_vis  = new_pulse & vis;
  wire                  any_new  = |new_vis;
  wire                  any_flash = |(unacked & vis);
  wire                  any_act  = |(active & vis);
  wire                  beacon_next = any_flash ? flash_ph_reg : any_act;
  wire                  flash_wrap = flash_cnt_reg >= 32'(FLASH_HALF - 1);
  wire                  any_clear = |(active & ~{cond_s2_reg});

  logic [4:0] first_new;
  always_comb begin
    first_new = 5'h00;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (new_vis[i])
        first_new = 5'(i);
    end
  end

  // relays follow active alarms, events included
  assign relay_out       = active & relay_en_reg;
  assign beacon_on       = beacon_reg;
  assign message_request = msg_req_reg;
  assign message_source  = msg_src_reg;
  assign irq             = |(irq_st_reg & irq_mask_reg);
  assign prdata          = prdata_reg;

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RESET_ZERO;
    unique case (1'b1)
      hit_st: rd_mux = 32'(active);
      hit_cd: rd_mux = 32'(cond_s2_reg);
      hit_le: rd_mux = 32'(cfg_reg.latch_en);
      hit_mn: rd_mux = 32'(cfg_reg.manual);
      hit_ev: rd_mux = 32'(cfg_reg.event_only);
      hit_re: rd_mux = 32'(relay_en_reg);
      hit_is: rd_mux = 32'(irq_st_reg);
      hit_im: rd_mux = 32'(irq_mask_reg);
      hit_ms: rd_mux = {26'h0, msg_req_reg, msg_src_reg};
      hit_sm: rd_mux = 32'(unacked);
      default: rd_mux = RESET_ZERO;
    endcase
  end

  // synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cond_s1_reg <= '0;
      cond_s2_reg <= '0;
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      pin_d_reg   <= '0;
    end else begin
      cond_s1_reg <= alarm_cond;
      cond_s2_reg <= cond_s1_reg;
      pin_s1_reg  <= {global_ack_pin, digital_ack_pin, button_ack_pin};
      pin_s2_reg  <= pin_s1_reg;
      pin_d_reg   <= pin_s2_reg;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_reg      <= '0;
      relay_en_reg <= '0;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (hit_le) cfg_reg.latch_en   <= req.pwdata[NUM_ALARMS-1:0];
      if (hit_mn) cfg_reg.manual     <= req.pwdata[NUM_ALARMS-1:0];
      if (hit_ev) cfg_reg.event_only <= req.pwdata[NUM_ALARMS-1:0];
      if (hit_re) relay_en_reg       <= req.pwdata[NUM_ALARMS-1:0];
      if (hit_im) irq_mask_reg       <= req.pwdata[NUM_IRQ-1:0];
    end
  end

  // sticky interrupts, set wins over write-one clear
  wire [NUM_IRQ-1:0] irq_set = {any_clear, any_new};
  wire [NUM_IRQ-1:0] irq_clr = (wr_en & hit_is) ? req.pwdata[NUM_IRQ-1:0] : '0;
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      irq_st_reg <= '0;
    else
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
  end

  // beacon flash timer and message latch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flash_cnt_reg <= '0;
      flash_ph_reg  <= 1'b1;
      beacon_reg    <= 1'b0;
      msg_req_reg   <= 1'b0;
      msg_src_reg   <= '0;
    end else begin
      if (any_new) begin
        flash_cnt_reg <= '0;
        flash_ph_reg  <= 1'b1;
      end else if (flash_wrap) begin
        flash_cnt_reg <= '0;
        flash_ph_reg  <= ~flash_ph_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      end
      beacon_reg <= beacon_next;
      if (any_new) begin
        msg_req_reg <= 1'b1;
        msg_src_reg <= first_new;
      end else if (!any_flash) begin
        msg_req_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      prdata_reg <= '0;
    else if (req.psel && !req.penable && !req.pwrite)
      prdata_reg <= rd_mux;
  end
endmodule
`default_nettype wire

// ==== alarm_latch_checker.sv ====
// concurrent checks on the alarm latch top ports
`timescale 1ns/10ps
`default_nettype none
module alarm_latch_checker
  import alarm_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic [7:0]             paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   beacon_on,
  input wire logic                   message_request,
  input wire logic [NUM_ALARMS-1:0]  relay_out,
  input wire logic [2*NUM_LOOPS-1:0] loop_alarm_status_pair,
  input wire logic [1:0]             process_variable_status,
  input wire logic [1:0]             analogue_status,
  input wire logic [NUM_MODS-1:0]    module_low_status_vector,
  input wire logic [NUM_MODS-1:0]    module_high_status_vector,
  input wire logic [NUM_USER-1:0]    user_status_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [NUM_ALARMS-1:0] st_all;
  assign st_all = {user_status_vector, module_high_status_vector, module_low_status_vector,
                   analogue_status, process_variable_status, loop_alarm_status_pair};
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in transfer");
  property p_unmapped;
    psel && penable && paddr > ADDR_SUMMARY |-> pslverr && (pwrite || prdata == RESET_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    psel && penable && paddr <= ADDR_SUMMARY && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_errphase; pslverr |-> psel && penable; endproperty
  a_errphase: assert property (p_errphase) else $error("error outside access");
  property p_mod2;
    !module_low_status_vector[MOD_UNFITTED] && !module_high_status_vector[MOD_UNFITTED];
  endproperty
  a_mod2: assert property (p_mod2) else $error("unfitted module shows alarm");
  property p_relay; (relay_out & ~st_all) == '0; endproperty
  a_relay: assert property (p_relay) else $error("relay on without active alarm");
  property p_rst;
    $rose(rst_n) |-> !beacon_on && !message_request && relay_out == '0 && st_all == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_msg; $rose(message_request) |-> |st_all; endproperty
  a_msg: assert property (p_msg) else $error("message without alarm");
endmodule
bind alarm_latch_top alarm_latch_checker #(.FLASH_HALF(FLASH_HALF)) u_chk (
  .ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .beacon_on, .message_request, .relay_out, .loop_alarm_status_pair,
  .process_variable_status, .analogue_status, .module_low_status_vector,
  .module_high_status_vector, .user_status_vector);
`default_nettype wire

// ==== ack_panel.sv ====
// operator acknowledge sources: button, digital input, global
`timescale 1ns/10ps
`default_nettype none
module ack_panel (
  input  wire logic       ref_clk,
  input  wire logic [2:0] press,
  output logic      [2:0] pins
);
  // known idle from time zero, so no unknown reaches the pin synchronisers
  logic [2:0] hold_reg [3] = '{default: 3'h0};
  // each press held three cycles, idle low
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      hold_reg[i] <= {hold_reg[i][1:0], press[i]};
    end
  end
  assign pins = {|hold_reg[2], |hold_reg[1], |hold_reg[0]};
endmodule
`default_nettype wire

// ==== latching_alarm_status_ack_tb.sv ====
// self-checking bench for the alarm latch top
`timescale 1ns/10ps
`default_nettype none
module latching_alarm_status_ack_tb
  import alarm_pkg::*;
;
  localparam int FLASH_T = 4;
  localparam logic [29:0] ALL = 30'h3FFF_FFFF;
  localparam logic [29:0] FIT = 30'h3FFD_F7FF;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [NUM_ALARMS-1:0] alarm_cond, relay_out, exp;
  logic [2:0] press, pins;
  logic beacon_on, message_request, irq;
  logic [4:0] message_source;
  logic [5:0] loop_alarm_status_pair, module_low_status_vector, module_high_status_vector;
  logic [1:0] process_variable_status, analogue_status;
  logic [7:0] user_status_vector;
  int err_count, samples_checked, cyc, seed, n;
  alarm_latch_top #(.FLASH_HALF(FLASH_T)) u_dut (
    .ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .alarm_cond, .button_ack_pin(pins[0]), .digital_ack_pin(pins[1]),
    .global_ack_pin(pins[2]), .beacon_on, .message_request, .message_source, .relay_out,
    .loop_alarm_status_pair, .process_variable_status, .analogue_status,
    .module_low_status_vector, .module_high_status_vector, .user_status_vector, .irq);
  ack_panel u_pan (.ref_clk, .press, .pins);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [29:0] st();
    return {user_status_vector, module_high_status_vector, module_low_status_vector,
            analogue_status, process_variable_status, loop_alarm_status_pair};
  endfunction
  function automatic logic [29:0] gm(input int g);
    gm = '0;
    if (g < 5) gm[2*g +: 2] = 2'b11;
    else begin
      gm[IDX_MLO+g-5] = 1'b1;
      gm[IDX_MHI+g-5] = 1'b1;
    end
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ack(input int i);
    @(posedge ref_clk);
    press <= 3'b001 << i;
    @(posedge ref_clk);
    press <= 3'b000;
    wt(8);
  endtask
  task automatic cset(input logic [29:0] v);
    alarm_cond <= v;
    wt(5);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    seed = 14612; err_count = 0; samples_checked = 0; cyc = 0; rst_n = 1'b0;
    press = '0; alarm_cond = '0; paddr = '0; psel = 0; penable = 0; pwrite = 0; pwdata = '0;
    wt(2);
    rst_n <= 1'b1;
    n = $random(seed);
    apb(1, ADDR_LATCH_EN, n);
    apb(0, ADDR_LATCH_EN, 0);
    chk(rdata, {2'b00, n[29:0]});
    apb(0, 8'h40, 0);
    chk({rerr, rdata[30:0]}, 32'h8000_0000);
    apb(1, ADDR_LATCH_EN, ALL);
    apb(1, ADDR_RELAY_EN, ALL);
    cset(30'h1);
    chk({message_request, relay_out[0], 30'(st())}, 32'hC000_0001);
    ack(0);
    n = 0;
    repeat (12) begin wt(1); n += beacon_on; end
    chk(n, 12);
    chk(32'(st()), 1);
    cset(30'h5);
    chk(32'(message_source), 2);
    n = 0;
    repeat (12) begin wt(1); n += !beacon_on; end
    chk(32'(n > 0), 1);
    cset(30'h0);
    chk(32'(st()), 4);
    ack(1);
    chk({beacon_on, 30'(st())}, 0);
    chk(32'(irq), 0);
    apb(1, ADDR_IRQ_MASK, 1);
    wt(1);
    chk(32'(irq), 1);
    apb(1, ADDR_IRQ_ST, 32'h3);
    wt(1);
    chk(32'(irq), 0);
    apb(1, ADDR_MANUAL, ALL);
    n = $random(seed);
    exp = n[29:0] & FIT;
    cset(n[29:0]);
    ack(2);
    cset(30'h0);
    chk(32'(st()), 32'(exp));
    apb(0, ADDR_IRQ_ST, 0);
    chk(rdata, (exp != '0) ? 32'h3 : 32'h0);
    for (int g = 0; g < NUM_GROUPS; g++) begin
      apb(1, ADDR_ACK_GRP, 32'h1 << g);
      wt(2);
      exp &= ~gm(g);
      chk(32'(st()), 32'(exp));
    end
    for (int u = 0; u < NUM_USER; u++) begin
      apb(1, ADDR_ACK_USER, 32'h1 << u);
      wt(2);
      exp[IDX_USER+u] = 1'b0;
      chk(32'(st()), 32'(exp));
    end
    cset(ALL);
    cset(30'h0);
    apb(1, ADDR_ACK_GRP, ACK_ALL_BIT);
    wt(2);
    chk(32'(st()), 0);
    apb(1, ADDR_EVENT, ALL);
    apb(1, ADDR_MANUAL, 0);
    apb(1, ADDR_LATCH_EN, 0);
    cset(ALL);
    chk({beacon_on, message_request, 30'(st())}, 32'(FIT));
    rst_n <= 1'b0;
    wt(2);
    chk({beacon_on, message_request, 30'(st())}, 0);
    chk(32'(relay_out), 0);
    rst_n <= 1'b1;
    alarm_cond <= '0;
    wt(4);
    end_sim();
  end
endmodule
`default_nettype wire
